// [pkg/reac_pkg.sv]
package reac_pkg;
  localparam int NUM_CH = 4;
  localparam int TABLE_N = 32;
  localparam int TAP_N = 5;
  localparam int DATA_W = 20;
  localparam int FIFO_DEPTH = 8;
  localparam int COARSE_N = 16;

  localparam logic [7:0] CTRL_ADDR = 8'h30;
  localparam logic [7:0] CMD_ADDR = 8'h31;
  localparam logic [7:0] STAT_ADDR = 8'h32;
  localparam logic [7:0] BOOST_ADDR = 8'h33;
  localparam logic [7:0] LEVEL_ADDR = 8'h34;
  localparam logic [7:0] TARGET_ADDR = 8'h35;
  localparam logic [7:0] COARSE_ADDR = 8'h36;
  localparam logic [7:0] MANIDX_ADDR = 8'h37;
  localparam logic [7:0] TAP_BASE = 8'h38;
  localparam logic [7:0] MON_ADDR = 8'h3E;
  localparam logic [7:0] TABLE_BASE = 8'h40;
  localparam logic [7:0] TABLE_LAST = 8'h5F;

  localparam int MON_BIT = 7;
  localparam int CTRL_SD_OVR = 0;
  localparam int CTRL_SD_ON = 1;
  localparam int CTRL_LIMIT = 2;
  localparam int CTRL_DFE = 3;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_PRBS = 6;
  localparam int CMD_READAPT = 0;
  localparam int CMD_CDR_RST = 1;
  localparam int TAP_POL = 7;

  localparam logic [7:0] CTRL_RST = 8'h10;
  localparam logic [7:0] MON_RST = 8'h80;
  localparam logic [7:0] TARGET_RST = 8'h80;
  localparam logic [7:0] TAP_RST = 8'h00;
  localparam logic [7:0] TABLE_RST = 8'h00;
  localparam logic [4:0] MANIDX_RST = 5'h00;

  localparam int CLK_NS = 10;
  localparam int SETTLE_NS = 1000;
  localparam int QUAL_NS = 2000;
  localparam int QUAL_MON_NS = 12000;
  localparam int ATTEMPT_NS = 20000;
  localparam logic [15:0] SETTLE_CYC = 16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] QUAL_CYC = 12'((QUAL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] QUAL_MON_CYC =
    12'((QUAL_MON_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ATTEMPT_CYC =
    16'((ATTEMPT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] CAL_WIN_REF = 8'h40;
  localparam logic [2:0] RELOCK_TRIES = 3'h4;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_CAL = 5'b00010,
    ST_ADAPT = 5'b00100,
    ST_LOCKWAIT = 5'b01000,
    ST_LOCKED = 5'b10000
  } reac_state_e;
endpackage

// [src/reac_top.sv]
`timescale 1ns/1ps
`default_nettype none

module reac_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } reac_fifo_s;
  reac_fifo_s s_q, s_d;
  logic push, pop;

  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

module reac_top
  import reac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Host register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [1:0] reg_chan,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // EEPROM loader write port
  input wire logic load_busy,
  input wire logic load_wr_en,
  input wire logic [1:0] load_chan,
  input wire logic [7:0] load_addr,
  input wire logic [7:0] load_wdata,
  // Analog status per channel, plus one reference tick shared by all channels
  input wire logic [reac_pkg::NUM_CH-1:0] sig_present,
  input wire logic [reac_pkg::NUM_CH-1:0] loop_lock_raw,
  input wire logic [reac_pkg::NUM_CH-1:0] eye_open_ok,
  input wire logic [reac_pkg::NUM_CH-1:0][7:0] quality_score,
  input wire logic [reac_pkg::NUM_CH-1:0] vco_div_tick,
  input wire logic ref_tick,
  // Analog controls per channel
  output logic [reac_pkg::NUM_CH-1:0] path_power_on,
  output logic [reac_pkg::NUM_CH-1:0][7:0] boost_setting,
  output logic [reac_pkg::NUM_CH-1:0] stage4_limiting,
  output logic [reac_pkg::NUM_CH-1:0] tap_eq_enable,
  output logic [reac_pkg::NUM_CH-1:0] tap_eq_adapt_run,
  output logic [reac_pkg::NUM_CH-1:0][reac_pkg::TAP_N-1:0][7:0] tap_setting,
  output logic [reac_pkg::NUM_CH-1:0][3:0] coarse_tune,
  output logic [reac_pkg::NUM_CH-1:0] loop_reset,
  output logic [reac_pkg::NUM_CH-1:0] pattern_gen_en,
  output logic [reac_pkg::NUM_CH-1:0] chan_locked,
  // Data stream per channel
  input wire logic [reac_pkg::NUM_CH-1:0][reac_pkg::DATA_W-1:0] rx_data,
  input wire logic [reac_pkg::NUM_CH-1:0] rx_valid,
  output logic [reac_pkg::NUM_CH-1:0] rx_ready,
  output logic [reac_pkg::NUM_CH-1:0][reac_pkg::DATA_W-1:0] tx_data,
  output logic [reac_pkg::NUM_CH-1:0] tx_valid,
  input wire logic [reac_pkg::NUM_CH-1:0] tx_ready
);
  import reac_pkg::*;

  typedef struct packed {
    logic [TABLE_N-1:0][7:0] table_mem;
    logic [7:0] ctrl;
    logic [7:0] mon;
    logic [7:0] target;
    logic [4:0] man_idx;
    logic [TAP_N-1:0][7:0] taps;
    reac_state_e st;
    logic [15:0] timer;
    logic [11:0] qual;
    logic [4:0] idx;
    logic [4:0] best_idx;
    logic [7:0] best_score;
    logic [3:0] coarse;
    logic [3:0] best_coarse;
    logic [8:0] best_err;
    logic [7:0] ref_cnt;
    logic [8:0] vco_cnt;
    logic [2:0] tries;
    logic [7:0] boost;
  } reac_chan_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } reac_top_s;

  reac_top_s t_q, t_d;
  logic wr_en;
  logic [1:0] wr_chan;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [NUM_CH-1:0][7:0] chan_rd;

  // ****************************************
  // Write source select
  // ****************************************
  always_comb begin
    if (load_busy) begin
      wr_en = load_wr_en;
      wr_chan = load_chan;
      wr_addr = load_addr;
      wr_data = load_wdata;
    end else begin
      wr_en = reg_wr_en;
      wr_chan = reg_chan;
      wr_addr = reg_addr;
      wr_data = reg_wdata;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    reac_chan_s c_q, c_d;
    logic sel, pwr, lock_ok, readapt, loop_rst;
    logic [8:0] err;
    logic [11:0] qual_need;
    logic [1:0] mode;
    logic [7:0] level;
    logic [7:0] rd;
    logic fifo_ready;

    assign sel = wr_en && (wr_chan == 2'(g));
    assign readapt = sel && (wr_addr == CMD_ADDR) && wr_data[CMD_READAPT];
    assign loop_rst = sel && (wr_addr == CMD_ADDR) && wr_data[CMD_CDR_RST];
    assign mode = c_q.ctrl[CTRL_MODE_LO+1:CTRL_MODE_LO];
    assign pwr = c_q.ctrl[CTRL_SD_OVR] ? c_q.ctrl[CTRL_SD_ON]
                                       : sig_present[g];
    assign lock_ok = loop_lock_raw[g] &&
                     (!c_q.mon[MON_BIT] || eye_open_ok[g]);
    assign qual_need = c_q.mon[MON_BIT] ? QUAL_MON_CYC : QUAL_CYC;
    assign err = (c_q.vco_cnt >= {1'b0, c_q.target}) ?
                 c_q.vco_cnt - {1'b0, c_q.target} :
                 {1'b0, c_q.target} - c_q.vco_cnt;
    assign level = 8'({6'h00, c_q.boost[1:0]} + {6'h00, c_q.boost[3:2]} +
                      {6'h00, c_q.boost[5:4]} + {6'h00, c_q.boost[7:6]});

    always_comb begin
      c_d = c_q;
      // Register writes
      if (sel) begin
        if (wr_addr >= TABLE_BASE && wr_addr <= TABLE_LAST) begin
          c_d.table_mem[wr_addr[4:0]] = wr_data;
        end
        if (wr_addr == CTRL_ADDR) c_d.ctrl = wr_data;
        if (wr_addr == MON_ADDR) c_d.mon = wr_data;
        if (wr_addr == TARGET_ADDR) c_d.target = wr_data;
        if (wr_addr == MANIDX_ADDR) c_d.man_idx = wr_data[4:0];
        for (int k = 0; k < TAP_N; k++) begin
          if (wr_addr == TAP_BASE + 8'(k)) c_d.taps[k] = wr_data;
        end
      end
      // Sequencer
      unique case (c_q.st)
        ST_OFF: begin
          if (pwr) begin
            c_d.st = ST_CAL;
            c_d.coarse = '0;
            c_d.best_err = '1;
            c_d.ref_cnt = '0;
            c_d.vco_cnt = '0;
          end
        end
        ST_CAL: begin
          if (ref_tick) c_d.ref_cnt = c_q.ref_cnt + 1'b1;
          if (vco_div_tick[g] && c_q.vco_cnt != '1) begin
            c_d.vco_cnt = c_q.vco_cnt + 1'b1;
          end
          if (c_q.ref_cnt == CAL_WIN_REF) begin
            c_d.ref_cnt = '0;
            c_d.vco_cnt = '0;
            c_d.coarse = c_q.coarse + 1'b1;
            if (err < c_q.best_err) begin
              c_d.best_err = err;
              c_d.best_coarse = c_q.coarse;
            end
            if (c_q.coarse == 4'(COARSE_N - 1)) begin
              c_d.coarse = (err < c_q.best_err) ? c_q.coarse
                                                : c_q.best_coarse;
              c_d.tries = '0;
              c_d.timer = '0;
              c_d.qual = '0;
              c_d.idx = '0;
              c_d.best_score = '0;
              c_d.best_idx = '0;
              if (mode == 2'h0) begin
                c_d.boost = c_q.table_mem[c_q.man_idx];
                c_d.st = ST_LOCKWAIT;
              end else begin
                c_d.boost = c_q.table_mem[0];
                c_d.st = ST_ADAPT;
              end
            end
          end
        end
        ST_ADAPT: begin
          c_d.timer = c_q.timer + 1'b1;
          if (c_q.timer == SETTLE_CYC) begin
            c_d.timer = '0;
            if (c_q.idx == '0 || quality_score[g] > c_q.best_score) begin
              c_d.best_score = quality_score[g];
              c_d.best_idx = c_q.idx;
            end
            c_d.idx = c_q.idx + 1'b1;
            c_d.boost = c_q.table_mem[5'(c_q.idx + 1'b1)];
            if (c_q.idx == 5'(TABLE_N - 1)) begin
              c_d.boost = (c_q.idx == '0 ||
                           quality_score[g] > c_q.best_score) ?
                          c_q.table_mem[c_q.idx] :
                          c_q.table_mem[c_q.best_idx];
              c_d.qual = '0;
              c_d.st = ST_LOCKWAIT;
            end
          end
        end
        ST_LOCKWAIT: begin
          c_d.timer = c_q.timer + 1'b1;
          c_d.qual = lock_ok ? c_q.qual + 1'b1 : '0;
          if (lock_ok && c_q.qual == qual_need - 1'b1) begin
            c_d.st = ST_LOCKED;
            c_d.tries = '0;
          end else if (c_q.timer == ATTEMPT_CYC) begin
            c_d.timer = '0;
            c_d.qual = '0;
            c_d.tries = c_q.tries + 1'b1;
            if (c_q.tries == RELOCK_TRIES - 1'b1) begin
              c_d.st = ST_CAL;
              c_d.coarse = '0;
              c_d.best_err = '1;
              c_d.ref_cnt = '0;
              c_d.vco_cnt = '0;
            end
          end
        end
        ST_LOCKED: begin
          // Boost held here
          if (!loop_lock_raw[g]) begin
            c_d.st = ST_LOCKWAIT;
            c_d.timer = '0;
            c_d.qual = '0;
          end
        end
      endcase
      if (readapt && mode != 2'h0 &&
          (c_q.st == ST_LOCKED || c_q.st == ST_LOCKWAIT)) begin
        c_d.st = ST_ADAPT;
        c_d.idx = '0;
        c_d.timer = '0;
        c_d.best_score = '0;
        c_d.best_idx = '0;
        c_d.boost = c_q.table_mem[0];
      end
      if (loop_rst && c_q.st != ST_OFF) begin
        c_d.st = ST_CAL;
        c_d.coarse = '0;
        c_d.best_err = '1;
        c_d.ref_cnt = '0;
        c_d.vco_cnt = '0;
      end
      if (!pwr) begin
        c_d.st = ST_OFF;
      end
    end

    always_ff @(posedge clk) begin
      if (reset) begin
        c_q <= '0;
        c_q.table_mem <= {TABLE_N{TABLE_RST}};
        c_q.ctrl <= CTRL_RST;
        c_q.mon <= MON_RST;
        c_q.target <= TARGET_RST;
        c_q.man_idx <= MANIDX_RST;
        c_q.taps <= {TAP_N{TAP_RST}};
        c_q.st <= ST_OFF;
        c_q.best_err <= '1;
      end else begin
        c_q <= c_d;
      end
    end

    // Register read view
    always_comb begin
      rd = 8'h00;
      if (reg_addr >= TABLE_BASE && reg_addr <= TABLE_LAST) begin
        rd = c_q.table_mem[reg_addr[4:0]];
      end else if (reg_addr >= TAP_BASE &&
                   reg_addr < TAP_BASE + 8'(TAP_N)) begin
        rd = c_q.taps[3'(reg_addr - TAP_BASE)];
      end else begin
        unique case (reg_addr)
          CTRL_ADDR: rd = c_q.ctrl;
          STAT_ADDR: rd = {c_q.st, pwr, sig_present[g],
                           c_q.st == ST_LOCKED};
          BOOST_ADDR: rd = c_q.boost;
          LEVEL_ADDR: rd = level;
          TARGET_ADDR: rd = c_q.target;
          COARSE_ADDR: rd = {1'b0, c_q.tries, c_q.coarse};
          MANIDX_ADDR: rd = {3'h0, c_q.man_idx};
          MON_ADDR: rd = c_q.mon;
          default: rd = 8'h00;
        endcase
      end
    end
    assign chan_rd[g] = rd;

    // Analog controls
    assign path_power_on[g] = pwr;
    assign boost_setting[g] = c_q.boost;
    assign stage4_limiting[g] = c_q.ctrl[CTRL_LIMIT];
    assign tap_eq_enable[g] = c_q.ctrl[CTRL_DFE];
    assign tap_eq_adapt_run[g] = c_q.ctrl[CTRL_DFE] && mode[1] &&
      (c_q.st == ST_ADAPT || c_q.st == ST_LOCKWAIT ||
       c_q.st == ST_LOCKED);
    assign tap_setting[g] = c_q.taps;
    assign coarse_tune[g] = c_q.coarse;
    assign loop_reset[g] = (c_q.st == ST_CAL) || (c_q.st == ST_OFF);
    assign pattern_gen_en[g] = c_q.ctrl[CTRL_PRBS];
    assign chan_locked[g] = (c_q.st == ST_LOCKED);

    // Gated data path with buffering
    reac_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .clk(clk),
      .reset(reset || !pwr),
      .in_valid(rx_valid[g] && pwr),
      .in_ready(fifo_ready),
      .in_data(rx_data[g]),
      .out_valid(tx_valid[g]),
      .out_ready(tx_ready[g]),
      .out_data(tx_data[g])
    );
    assign rx_ready[g] = pwr && fifo_ready;
  end

  // ****************************************
  // Read data register
  // ****************************************
  always_comb begin
    t_d.rvalid = reg_rd_en;
    t_d.rdata = reg_rd_en ? chan_rd[reg_chan] : t_q.rdata;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign reg_rdata = t_q.rdata;
  assign reg_rvalid = t_q.rvalid;
endmodule

`default_nettype wire

// [verification/reac_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module reac_monitor
  import reac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic reg_rd_en,
  input wire logic reg_rvalid,
  // Channel status
  input wire logic [reac_pkg::NUM_CH-1:0] path_power_on,
  input wire logic [reac_pkg::NUM_CH-1:0] chan_locked,
  input wire logic [reac_pkg::NUM_CH-1:0][7:0] boost_setting,
  // Stream
  input wire logic [reac_pkg::NUM_CH-1:0][reac_pkg::DATA_W-1:0] rx_data,
  input wire logic [reac_pkg::NUM_CH-1:0] rx_valid,
  input wire logic [reac_pkg::NUM_CH-1:0] rx_ready,
  input wire logic [reac_pkg::NUM_CH-1:0][reac_pkg::DATA_W-1:0] tx_data,
  input wire logic [reac_pkg::NUM_CH-1:0] tx_valid,
  input wire logic [reac_pkg::NUM_CH-1:0] tx_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff reset;

  // ********
  // Register port and channel zero checks
  // ********
  a_read_answer: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd_en))
    else $error("read answer without request");
  a_ready_power: assert property (rx_ready[0] |-> path_power_on[0])
    else $error("input ready while path is off");
  a_dark_unlocked: assert property (
    !path_power_on[0] ##1 !path_power_on[0] |-> !chan_locked[0])
    else $error("locked while path is off");
  a_flush_off: assert property (
    $fell(path_power_on[0]) |-> ##[1:2] !tx_valid[0])
    else $error("buffer not flushed on power loss");
  a_out_hold: assert property (
    tx_valid[0] && !tx_ready[0] && path_power_on[0] ##1 path_power_on[0]
    |-> tx_valid[0] && $stable(tx_data[0]))
    else $error("stalled output word changed");
  a_first_word: assert property (
    rx_valid[0] && rx_ready[0] && !tx_valid[0] ##1 path_power_on[0]
    |-> tx_valid[0] && tx_data[0] == $past(rx_data[0]))
    else $error("pushed word not on output next cycle");
  a_boost_frozen: assert property (
    chan_locked[0] ##1 chan_locked[0] |-> $stable(boost_setting[0]))
    else $error("boost moved while locked");

  c_full: cover property (rx_valid[0] && !rx_ready[0] && path_power_on[0]);
  c_read: cover property (reg_rvalid);
  c_drop: cover property ($fell(path_power_on[0]));
  c_lock: cover property (chan_locked[0]);
endmodule

`default_nettype wire

// [verification/reac_tx_model.sv]
`timescale 1ns/1ps
`default_nettype none

module reac_tx_model
  import reac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench control
  input wire logic send,
  // Stream towards the device
  input wire logic [reac_pkg::NUM_CH-1:0] ready,
  output logic [reac_pkg::NUM_CH-1:0] valid,
  output logic [reac_pkg::NUM_CH-1:0][reac_pkg::DATA_W-1:0] data
);
  logic [NUM_CH-1:0][DATA_W-1:0] cnt_q;

  // Word offered until taken, then next count
  always_ff @(posedge clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (reset) begin
        cnt_q[c] <= '0;
        valid[c] <= 1'b0;
      end else begin
        if (valid[c] && ready[c]) begin
          cnt_q[c] <= cnt_q[c] + 1'b1;
        end
        valid[c] <= send || (valid[c] && !ready[c]);
      end
    end
  end

  // Idle lines show the inverse, never a stale word
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      data[c] = valid[c] ? cnt_q[c] : ~cnt_q[c];
    end
  end
endmodule

`default_nettype wire

// [verification/retimer_equalizer_adapt_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module retimer_equalizer_adapt_control_tb;
  import reac_pkg::*;
  logic clk, reset, reg_wr_en, reg_rd_en, reg_rvalid;
  logic load_busy, load_wr_en, send;
  logic [1:0] reg_chan, load_chan;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, load_addr, load_wdata;
  logic [NUM_CH-1:0] sig_present, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [NUM_CH-1:0] path_power_on, stage4_limiting, tap_eq_enable;
  logic [NUM_CH-1:0] pattern_gen_en;
  logic [NUM_CH-1:0] loop_lock_raw, eye_open_ok, vco_div_tick, loop_reset;
  logic [NUM_CH-1:0] tap_eq_adapt_run, chan_locked;
  logic ref_tick;
  logic [NUM_CH-1:0][7:0] quality_score, boost_setting;
  logic [NUM_CH-1:0][3:0] coarse_tune;
  localparam logic [7:0] PEAK_BOOST = 8'(7 * 8'h25 + 8'h1B);
  logic [NUM_CH-1:0][DATA_W-1:0] rx_data, tx_data;
  logic [NUM_CH-1:0][TAP_N-1:0][7:0] tap_setting;
  int fail_count, n_compared;

  reac_top dut (
    .clk(clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_chan(reg_chan), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .load_busy(load_busy),
    .load_wr_en(load_wr_en), .load_chan(load_chan), .load_addr(load_addr),
    .load_wdata(load_wdata), .sig_present(sig_present),
    .loop_lock_raw(loop_lock_raw), .eye_open_ok(eye_open_ok),
    .quality_score(quality_score), .vco_div_tick(vco_div_tick),
    .ref_tick(ref_tick), .path_power_on(path_power_on),
    .boost_setting(boost_setting), .stage4_limiting(stage4_limiting),
    .tap_eq_enable(tap_eq_enable), .tap_eq_adapt_run(tap_eq_adapt_run),
    .tap_setting(tap_setting), .coarse_tune(coarse_tune),
    .loop_reset(loop_reset), .pattern_gen_en(pattern_gen_en),
    .chan_locked(chan_locked), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready)
  );

  reac_tx_model far_end (.clk(clk), .reset(reset), .send(send),
    .ready(rx_ready), .valid(rx_valid), .data(rx_data));

  // Analog stand-in: one coarse step and one table entry stand out
  always @(posedge clk) begin
    vco_div_tick <= {3'h0, coarse_tune[0] == 4'h5};
    quality_score <= {24'h0,
      (boost_setting[0] == PEAK_BOOST) ? 8'hC0 : 8'h40};
  end

  // ********
  // Access tasks
  // ********
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] ch, input logic [7:0] a, d);
    @(posedge clk);
    {reg_chan, reg_addr, reg_wdata, reg_wr_en} <= {ch, a, d, 1'b1};
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic rdx(input logic [1:0] ch, input logic [7:0] a, exp);
    @(posedge clk);
    {reg_chan, reg_addr, reg_rd_en} <= {ch, a, 1'b1};
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1 check(reg_rvalid, 1'b1);
    check(reg_rdata, exp);
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    fail_count++;
    close_out;
  end

  // ********
  // Test sequence
  // ********
  initial begin
    fail_count = 0;
    n_compared = 0;
    reset = 1'b1;
    {reg_wr_en, reg_rd_en, load_busy, load_wr_en, send} = '0;
    {reg_chan, load_chan, reg_addr, reg_wdata, load_addr, load_wdata} = '0;
    {sig_present, tx_ready} = '0;
    {loop_lock_raw, eye_open_ok, ref_tick} = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      rdx(2'(c), CTRL_ADDR, CTRL_RST);
      rdx(2'(c), MON_ADDR, MON_RST);
    end
    check(path_power_on, 4'h0);
    // Automatic gating, then override off and on
    @(posedge clk);
    sig_present <= 4'hF;
    @(posedge clk);
    #1 check(path_power_on, 4'hF);
    wr(2'h2, CTRL_ADDR, 8'h11);
    #1 check(path_power_on, 4'hB);
    @(posedge clk);
    sig_present <= 4'h0;
    wr(2'h2, CTRL_ADDR, 8'h13);
    #1 check(path_power_on, 4'h4);
    wr(2'h2, CTRL_ADDR, CTRL_RST);
    // Control bits per channel
    #1 check({pattern_gen_en, tap_eq_enable, stage4_limiting}, 12'h0);
    wr(2'h1, CTRL_ADDR, 8'h5C);
    #1 check({pattern_gen_en, tap_eq_enable, stage4_limiting}, 12'h222);
    rdx(2'h1, CTRL_ADDR, 8'h5C);
    for (int i = 0; i < TAP_N; i++) begin
      wr(2'h3, TAP_BASE + 8'(i), 8'(8'h81 + i * 8'h3B));
    end
    for (int i = 0; i < TAP_N; i++) begin
      check(tap_setting[3][i], 8'(8'h81 + i * 8'h3B));
      rdx(2'h3, TAP_BASE + 8'(i), 8'(8'h81 + i * 8'h3B));
    end
    check(tap_setting[0], 40'h0);
    // Boost table, edges of its range
    for (int e = 0; e < TABLE_N; e++) begin
      wr(2'h0, TABLE_BASE + 8'(e), 8'(e * 8'h25 + 8'h1B));
    end
    for (int e = 0; e < TABLE_N; e++) begin
      rdx(2'h0, TABLE_BASE + 8'(e), 8'(e * 8'h25 + 8'h1B));
    end
    rdx(2'h1, TABLE_LAST, TABLE_RST);
    wr(2'h0, TABLE_LAST + 8'h01, 8'hA5);
    rdx(2'h0, TABLE_LAST + 8'h01, 8'h00);
    wr(2'h0, MON_ADDR, 8'h00);
    rdx(2'h0, MON_ADDR, 8'h00);
    rdx(2'h1, MON_ADDR, MON_RST);
    // Loader owns writes while busy
    @(posedge clk);
    load_busy <= 1'b1;
    wr(2'h0, TABLE_BASE, 8'hEE);
    @(posedge clk);
    {load_chan, load_addr, load_wdata, load_wr_en} <=
      {2'h0, TABLE_BASE + 8'h01, 8'h5A, 1'b1};
    @(posedge clk);
    load_wr_en <= 1'b0;
    load_busy <= 1'b0;
    rdx(2'h0, TABLE_BASE, 8'h1B);
    rdx(2'h0, TABLE_BASE + 8'h01, 8'h5A);
    // Fill the buffer with the drain stalled, then empty it
    @(posedge clk);
    sig_present <= 4'h1;
    send <= 1'b1;
    repeat (14) @(posedge clk);
    #1 check(rx_ready[0], 1'b0);
    @(posedge clk);
    send <= 1'b0;
    tx_ready <= 4'h1;
    // Word held at the full input lands once room frees
    for (int k = 0; k <= FIFO_DEPTH; k++) begin
      #1 check(tx_data[0], 20'(k));
      @(posedge clk);
    end
    #1 check(tx_valid[0], 1'b0);
    // Power loss flushes the buffer
    @(posedge clk);
    tx_ready <= 4'h0;
    send <= 1'b1;
    repeat (3) @(posedge clk);
    sig_present <= 4'h0;
    send <= 1'b0;
    repeat (3) @(posedge clk);
    sig_present <= 4'h1;
    repeat (2) @(posedge clk);
    // Flushed words gone, the word held over the outage comes first
    #1 check(tx_valid[0], 1'b1);
    check(tx_data[0], 20'h0000B);
    // Full acquisition on channel zero, both equalizers adapting
    wr(2'h0, CTRL_ADDR, 8'h28);
    wr(2'h0, MON_ADDR, MON_RST);
    wr(2'h0, CMD_ADDR, 8'h02);
    rdx(2'h0, STAT_ADDR, 8'h16);
    check(loop_reset[0], 1'b1);
    @(posedge clk);
    {ref_tick, loop_lock_raw, eye_open_ok} <= {1'b1, 4'h1, 4'h1};
    repeat (5700) @(posedge clk);
    #1 check(chan_locked[0], 1'b1);
    check(boost_setting[0], PEAK_BOOST);
    check(tap_eq_adapt_run[0], 1'b1);
    check(coarse_tune[0], 4'h5);
    rdx(2'h0, LEVEL_ADDR, 8'h06);
    // Lock loss relocks on the frozen boost
    @(posedge clk);
    loop_lock_raw <= 4'h0;
    repeat (2) @(posedge clk);
    loop_lock_raw <= 4'h1;
    #1 check(chan_locked[0], 1'b0);
    check(boost_setting[0], PEAK_BOOST);
    repeat (1100) @(posedge clk);
    #1 check(chan_locked[0], 1'b0);
    repeat (200) @(posedge clk);
    #1 check(chan_locked[0], 1'b1);
    check(boost_setting[0], PEAK_BOOST);
    close_out;
  end
endmodule

bind reac_top reac_monitor mon (.clk(clk), .reset(reset),
  .reg_rd_en(reg_rd_en), .reg_rvalid(reg_rvalid),
  .path_power_on(path_power_on), .chan_locked(chan_locked),
  .boost_setting(boost_setting), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready));

`default_nettype wire
